// ---- ea_ext_decoder.sv ----
`timescale 1ns/1ps
module ea_ext_decoder (
	// clock and reset
	input  wire logic                        clk,
	input  wire logic                        nrst,
	// instruction word from fetch
	input  wire logic                        start,
	input  wire logic                        clear_count,
	input  wire logic [15:0]                 instr_word,
	input  wire ea_pkg::size_e               op_size,
	input  wire logic                        coproc,
	input  wire logic [7:0]                  coproc_words,
	// extension word stream
	input  wire logic                        word_valid,
	input  wire logic [15:0]                 word,
	output logic                             word_ready,
	// decoded result to address datapath
	output logic                             done,
	output logic                             illegal,
	output ea_pkg::ea_ctl_s                  ctl,
	output logic [7:0]                       ext_count,
	// stash read back
	input  wire logic [ea_pkg::STASH_AW-1:0] rd_idx,
	output logic [15:0]                      rd_data
);
	import ea_pkg::*;

	dec_state_s r;
	dec_state_s n;
	logic       take;
	logic       ext7;
	logic       bad;
	logic [2:0] iis;
	logic [2:0] md;
	logic [2:0] rg;

	assign take = word_valid && r.word_ready;
	assign md   = instr_word[MODE_LO+:3];
	assign rg   = instr_word[EAREG_LO+:3];
	assign ext7 = (md == MODE_EXT);
	assign iis  = word[IIS_LO+:3];

	// ==========================================
	// next state
	always_comb begin
		n         = r;
		n.done    = 1'b0;
		n.illegal = 1'b0;
		bad       = 1'b0;
		case (r.st)
			ST_IDLE: begin
				if (start) begin
					n.ctl        = '0;
					n.ctl.mode   = md;
					n.ctl.ea_reg = rg;
					n.sz         = op_size;
					n.imm        = 1'b0;
					n.left       = 8'h0;
					if (clear_count) begin
						n.ext_count = 8'h0;
					end
					if (md == MODE_IDX || (ext7 && rg == REG_PC_IDX)) begin
						n.st = ST_FMT;
					end else if (md == MODE_DISP || (ext7 && (rg == REG_PC_DISP || rg == REG_ABS_W))) begin
						n.left = IMM_SHORT_N;
						n.st   = ST_OPND;
					end else if (ext7 && rg == REG_ABS_L) begin
						n.left = ABS_LONG_N;
						n.st   = ST_OPND;
					end else if (ext7 && rg == REG_IMM) begin
						n.imm = 1'b1;
						if (coproc) begin
							n.left = coproc_words; // any size for coprocessor
						end else begin
							n.left = (op_size == SZ_LONG) ? IMM_LONG_N : IMM_SHORT_N;
						end
						n.st   = (n.left == 8'h0) ? ST_IDLE : ST_OPND;
						n.done = (n.left == 8'h0);
					end else if (ext7) begin
						n.illegal = 1'b1; // unused register codes under 111
					end else begin
						n.done = 1'b1; // register modes need no words
					end
				end
			end
			ST_OPND: begin
				if (take) begin
					n.ctl.operand = {r.ctl.operand[15:0], word}; // earlier word moves up
					n.ext_count   = r.ext_count + CNT_ONE;
					n.left        = r.left - CNT_ONE;
					if (r.left == CNT_ONE) begin
						n.st   = ST_IDLE;
						n.done = 1'b1;
						if (r.imm && !coproc && r.sz == SZ_BYTE) begin
							n.ctl.operand = {24'h0, word[7:0]};
						end else if (r.imm && !coproc && r.sz == SZ_WORD) begin
							n.ctl.operand = {16'h0, word};
						end else if (!r.imm && r.ctl.ea_reg != REG_ABS_L) begin
							n.ctl.operand = sext16(word); // short address or 16-bit displacement, except d16 off register 1, which stays zero-extended
						end
					end
				end
			end
			ST_FMT: begin
				if (take) begin
					n.ext_count       = r.ext_count + CNT_ONE;
					n.ctl.idx_addr    = word[DA_BIT];
					n.ctl.idx_reg     = word[IREG_LO+:3];
					n.ctl.idx_long    = word[WL_BIT];
					n.ctl.scale_shift = word[SCALE_LO+:2]; // shift 0..3 = times 1/2/4/8
					if (!word[FMT_BIT]) begin
						n.ctl.full_fmt  = 1'b0;
						n.ctl.base_add  = 1'b1;
						n.ctl.index_add = 1'b1;
						n.ctl.bd        = sext8(word[7:0]);
						n.st            = ST_IDLE;
						n.done          = 1'b1;
					end else begin
						n.ctl.full_fmt  = 1'b1;
						n.ctl.base_add  = !word[BS_BIT];
						n.ctl.index_add = !word[IS_BIT];
						n.ctl.bd_words  = words_of(word[BDS_LO+:2]);
						n.ctl.od_words  = words_of(iis[1:0]);
						n.ctl.indirect  = (iis != IIS_NONE);
						if (word[IS_BIT]) begin
							n.ctl.postindexed = 1'b0;
							bad               = iis[2];
						end else begin
							n.ctl.postindexed = iis[2];
							bad               = (iis == IIS_RSVD);
						end
						bad = bad || (word[BDS_LO+:2] == BDS_RSVD);
						if (bad) begin
							n.illegal = 1'b1; // no done, so no address goes out
							n.st      = ST_IDLE;
						end else if (n.ctl.bd_words != 2'h0) begin
							n.left = {6'h0, n.ctl.bd_words}; // base group first
							n.st   = ST_BD;
						end else if (n.ctl.od_words != 2'h0) begin
							n.left = {6'h0, n.ctl.od_words};
							n.st   = ST_OD;
						end else begin
							n.st   = ST_IDLE;
							n.done = 1'b1;
						end
					end
				end
			end
			ST_BD, ST_OD: begin
				if (take) begin
					n.ext_count = r.ext_count + CNT_ONE;
					n.left      = r.left - CNT_ONE;
					if (r.st == ST_BD) begin
						n.ctl.bd = (r.ctl.bd_words == 2'h1) ? sext16(word) : {r.ctl.bd[15:0], word};
					end else begin
						n.ctl.od = (r.ctl.od_words == 2'h1) ? sext16(word) : {r.ctl.od[15:0], word};
					end
					if (r.left == CNT_ONE) begin
						if (r.st == ST_BD && r.ctl.od_words != 2'h0) begin
							n.left = {6'h0, r.ctl.od_words}; // outer group second
							n.st   = ST_OD;
						end else begin
							n.st   = ST_IDLE;
							n.done = 1'b1;
						end
					end
				end
			end
			default: n.st = ST_IDLE;
		endcase
		// ready from a flop: true whenever the next state collects words
		n.word_ready = (n.st != ST_IDLE);
	end

	// ==========================================
	// state register
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			r    <= '0;
			r.st <= ST_IDLE;
			r.sz <= SZ_WORD;
		end else begin
			r <= n;
		end
	end

	assign word_ready = r.word_ready;
	assign done       = r.done;
	assign illegal    = r.illegal;
	assign ctl        = r.ctl;
	assign ext_count  = r.ext_count;

	// ==========================================
	// every taken word is kept for the datapath and for debug
	ext_word_stash u_stash (
		.clk   (clk),
		.nrst  (nrst),
		.we    (take),
		.waddr (r.ext_count[STASH_AW-1:0]),
		.wdata (word),
		.raddr (rd_idx),
		.rdata (rd_data)
	);

	// ==========================================
	// checks
	logic [15:0] hw1;
	logic [15:0] hw2;

	// last two taken words, only for the checks below
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			hw1 <= 16'h0;
			hw2 <= 16'h0;
		end else if (take) begin
			hw1 <= word;
			hw2 <= hw1;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	sequence s_fmt_take;
		r.st == ST_FMT && take;
	endsequence

	sequence s_full_legal;
		s_fmt_take ##0 (word[FMT_BIT] && word[BDS_LO+:2] != BDS_RSVD
			&& !(word[IS_BIT] ? iis[2] : (iis == IIS_RSVD)));
	endsequence

	a_brief_format: assert property (s_fmt_take ##0 !word[FMT_BIT] |=> done && !ctl.full_fmt
		&& ctl.bd == sext8($past(word[7:0])))
		else $error("brief word not decoded as brief");

	a_bds_reserved: assert property (s_fmt_take ##0 (word[FMT_BIT] && word[BDS_LO+:2] == BDS_RSVD)
		|=> illegal && !done)
		else $error("reserved base size not flagged");

	a_iis_res_is0: assert property (s_fmt_take ##0 (word[FMT_BIT] && !word[IS_BIT] && iis == IIS_RSVD)
		|=> illegal && !done && r.st == ST_IDLE)
		else $error("reserved select with index not flagged");

	a_iis_res_is1: assert property (s_fmt_take ##0 (word[FMT_BIT] && word[IS_BIT] && iis[2])
		|=> illegal && !done)
		else $error("reserved select without index not flagged");

	a_suppress_bits: assert property (s_full_legal |=> ctl.base_add == !$past(word[BS_BIT])
		&& ctl.index_add == !$past(word[IS_BIT]) && !illegal)
		else $error("suppress bits decoded wrongly");

	a_disp_order: assert property (s_full_legal ##0 (word[BDS_LO+:2] == 2'h3)
		|=> r.st == ST_BD && ctl.bd_words == 2'h2)
		else $error("base displacement not collected first");

	a_imm_byte: assert property (r.st == ST_OPND && take && r.imm && !coproc && r.sz == SZ_BYTE
		&& r.left == CNT_ONE |=> done && ctl.operand == {24'h0, $past(word[7:0])})
		else $error("byte immediate wrong");

	a_long_concat: assert property (done && r.imm && r.sz == SZ_LONG && !coproc
		|-> ctl.operand == {hw2, hw1})
		else $error("long immediate halves swapped");

	a_abs_long: assert property (done && !r.imm && ctl.mode == MODE_EXT && ctl.ea_reg == REG_ABS_L
		|-> ctl.operand == {hw2, hw1})
		else $error("absolute long halves swapped");

	a_imm_start: assert property (r.st == ST_IDLE && start && ext7 && rg == REG_IMM && !coproc
		|=> word_ready && r.left == ((r.sz == SZ_LONG) ? IMM_LONG_N : IMM_SHORT_N))
		else $error("immediate word count wrong");

	a_reg_mode: assert property (r.st == ST_IDLE && start && md < MODE_DISP
		|=> done && ctl.mode == $past(md) && !word_ready)
		else $error("register mode not finished at once");

endmodule

// ---- ea_pkg.sv ----
package ea_pkg;

	// ==========================================
	// instruction word and extension word fields
	localparam logic [2:0] MODE_DISP   = 3'h5;
	localparam logic [2:0] MODE_IDX    = 3'h6;
	localparam logic [2:0] MODE_EXT    = 3'h7;
	localparam logic [2:0] REG_ABS_W   = 3'h0;
	localparam logic [2:0] REG_ABS_L   = 3'h1;
	localparam logic [2:0] REG_PC_DISP = 3'h2;
	localparam logic [2:0] REG_PC_IDX  = 3'h3;
	localparam logic [2:0] REG_IMM     = 3'h4;
	localparam int         MODE_LO     = 3;
	localparam int         EAREG_LO    = 0;
	localparam int         DA_BIT      = 15;
	localparam int         IREG_LO     = 12;
	localparam int         WL_BIT      = 11;
	localparam int         SCALE_LO    = 9;
	localparam int         FMT_BIT     = 8;
	localparam int         BS_BIT      = 7;
	localparam int         IS_BIT      = 6;
	localparam int         BDS_LO      = 4;
	localparam int         IIS_LO      = 0;
	localparam logic [1:0] BDS_RSVD    = 2'h0;
	localparam logic [2:0] IIS_NONE    = 3'h0;
	localparam logic [2:0] IIS_RSVD    = 3'h4;

	// ==========================================
	// word stash and counters
	localparam int         STASH_AW    = 4;
	localparam int         STASH_DEPTH = 16;
	localparam logic [7:0] CNT_ONE     = 8'h01;
	localparam logic [7:0] IMM_SHORT_N = 8'h01;
	localparam logic [7:0] IMM_LONG_N  = 8'h02;
	localparam logic [7:0] ABS_LONG_N  = 8'h02;

	// ==========================================
	// types
	typedef enum logic [1:0] {SZ_BYTE = 2'h0, SZ_WORD = 2'h1, SZ_LONG = 2'h2} size_e;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_FMT  = 5'h02,
		ST_BD   = 5'h04,
		ST_OD   = 5'h08,
		ST_OPND = 5'h10
	} state_e;

	typedef struct packed {
		logic [2:0]  mode;
		logic [2:0]  ea_reg;
		logic        full_fmt;
		logic        idx_addr;
		logic [2:0]  idx_reg;
		logic        idx_long;
		logic [1:0]  scale_shift;
		logic        base_add;
		logic        index_add;
		logic [1:0]  bd_words;
		logic [1:0]  od_words;
		logic        indirect;
		logic        postindexed;
		logic [31:0] bd;
		logic [31:0] od;
		logic [31:0] operand;
	} ea_ctl_s;

	typedef struct packed {
		state_e      st;
		ea_ctl_s     ctl;
		size_e       sz;
		logic        imm;
		logic [7:0]  left;
		logic [7:0]  ext_count;
		logic        word_ready;
		logic        done;
		logic        illegal;
	} dec_state_s;

	// ==========================================
	// helpers
	// size code 01/10/11 -> 0/1/2 words; 00 gives 0, and a base size of 00 is caught as reserved elsewhere
	function automatic logic [1:0] words_of(input logic [1:0] code);
		words_of = (code == 2'h0) ? 2'h0 : code - 2'h1;
	endfunction

	function automatic logic [31:0] sext16(input logic [15:0] w);
		sext16 = {{16{w[15]}}, w};
	endfunction

	function automatic logic [31:0] sext8(input logic [7:0] b);
		sext8 = {{24{b[7]}}, b};
	endfunction

endpackage

// ---- ext_word_feeder.sv ----
`timescale 1ns/1ps
// ==========================================
// fetch side model: hands extension words over in order
module ext_word_feeder (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        nrst,
	// pacing
	input  wire logic        slow,
	// extension word stream
	input  wire logic        word_ready,
	output logic             word_valid,
	output logic [15:0]      word
);
	logic [15:0] q[$];
	logic        gap;

	// words are queued by the bench ahead of the start
	task automatic push(input logic [15:0] w);
		q.push_back(w);
	endtask

	// an offered word is held until taken; idle data flips so stale values never pass
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			word_valid <= 1'b0;
			word <= 16'hffff;
			gap <= 1'b0;
		end else if (!(word_valid && !word_ready)) begin
			if (word_valid)
				void'(q.pop_front());
			// slow pacing leaves every other cycle empty
			gap <= slow && !gap;
			if (q.size() > 0 && !(slow && !gap)) begin
				word_valid <= 1'b1;
				word <= q[0];
			end else begin
				word_valid <= 1'b0;
				word <= ~word;
			end
		end
	end
endmodule

// ---- ext_word_stash.sv ----
`timescale 1ns/1ps
module ext_word_stash (
	// clock and reset
	input  wire logic                          clk,
	input  wire logic                          nrst,
	// write side
	input  wire logic                          we,
	input  wire logic [ea_pkg::STASH_AW-1:0]   waddr,
	input  wire logic [15:0]                   wdata,
	// read side
	input  wire logic [ea_pkg::STASH_AW-1:0]   raddr,
	output logic      [15:0]                   rdata
);
	import ea_pkg::*;

	logic [15:0] mem [STASH_DEPTH];

	// ==========================================
	// storage, no reset on the array to keep it a plain RAM
	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata; // room for sixteen extension words of one instruction
		end
	end

	// ==========================================
	// registered read port
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdata <= 16'h0;
		end else begin
			rdata <= mem[raddr];
		end
	end

endmodule

// ---- tb_ea_ext_decoder.sv ----
`timescale 1ns/1ps
module tb_ea_ext_decoder;
	import ea_pkg::*;
	logic                clk, nrst, start, clear_count, coproc, slow;
	logic                word_valid, word_ready, done, illegal;
	logic [15:0]         instr_word, word, rd_data;
	logic [7:0]          coproc_words, ext_count;
	logic [STASH_AW-1:0] rd_idx;
	logic [1:0]          ans;
	size_e               op_size;
	ea_ctl_s             ctl;
	int                  error_cnt, compares, lat;

	ea_ext_decoder u_dut (.clk(clk), .nrst(nrst), .start(start), .clear_count(clear_count),
		.instr_word(instr_word), .op_size(op_size), .coproc(coproc), .coproc_words(coproc_words),
		.word_valid(word_valid), .word(word), .word_ready(word_ready), .done(done), .illegal(illegal),
		.ctl(ctl), .ext_count(ext_count), .rd_idx(rd_idx), .rd_data(rd_data));
	ext_word_feeder u_feed (.clk(clk), .nrst(nrst), .slow(slow), .word_ready(word_ready),
		.word_valid(word_valid), .word(word));

	// ==========================================
	// shared helpers
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic chk(input logic [127:0] got, input logic [127:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic stop_test();
		if (error_cnt == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// one decode: start is raised for one edge, then the answer is awaited under a bound
	task automatic dec(input logic [15:0] iw, input size_e sz, input logic cp, input logic [7:0] cw,
		input logic clr);
		@(posedge clk);
		start <= 1'b1;
		instr_word <= iw;
		op_size <= sz;
		coproc <= cp;
		coproc_words <= cw;
		clear_count <= clr;
		@(posedge clk);
		start <= 1'b0;
		// done or illegal stands for one cycle only, so look right after every edge
		for (lat = 0; lat < 60; lat++) begin
			#1;
			if (done === 1'b1 || illegal === 1'b1)
				break;
			@(posedge clk);
		end
		ans = {done, illegal};
	endtask

	function automatic logic [79:0] fv();
		return {ctl.full_fmt, ctl.idx_addr, ctl.idx_reg, ctl.idx_long, ctl.scale_shift, ctl.base_add,
			ctl.index_add, ctl.bd_words, ctl.od_words, ctl.indirect, ctl.postindexed, ctl.bd, ctl.od};
	endfunction

	// full format case: extension word, then up to four displacement words, high word first
	task automatic fcase(input logic [15:0] fw, input logic [63:0] dw, input int nd, input logic clr,
		input logic [79:0] ex, input logic [7:0] cnt);
		u_feed.push(fw);
		for (int i = 0; i < nd; i++)
			u_feed.push(dw[63-16*i -: 16]);
		dec({10'h0, MODE_IDX, 3'h2}, SZ_LONG, 1'b0, 8'h00, clr);
		chk(ans, 2'b10);
		chk(fv(), ex);
		chk(ext_count, cnt);
	endtask

	// ==========================================
	// scenarios
	task automatic t_modes();
		dec({10'h0, 3'h0, 3'h3}, SZ_WORD, 1'b0, 8'h00, 1'b1);
		chk({ans, lat, ctl.mode, ctl.ea_reg}, {2'b10, 32'd0, 3'h0, 3'h3});
		dec({10'h0, MODE_EXT, 3'h5}, SZ_WORD, 1'b0, 8'h00, 1'b1);
		chk(ans, 2'b01);
		u_feed.push(16'h8001);
		dec({10'h0, MODE_DISP, 3'h4}, SZ_WORD, 1'b0, 8'h00, 1'b1);
		chk({ans, ctl.mode, ctl.operand, ext_count}, {2'b10, MODE_DISP, 32'hffff8001, 8'h01});
		slow <= 1'b1;
		u_feed.push(16'h8123);
		u_feed.push(16'h4567);
		dec({10'h0, MODE_EXT, REG_ABS_L}, SZ_WORD, 1'b0, 8'h00, 1'b1);
		chk({ans, ctl.mode, ctl.ea_reg, ctl.operand, ext_count}, {2'b10, MODE_EXT, REG_ABS_L, 32'h81234567, 8'h02});
		slow <= 1'b0;
	endtask

	task automatic t_imm();
		logic [31:0] ex[3] = '{32'h000000a5, 32'h0000c3a5, 32'hc3a51e0f};
		for (int s = 0; s < 3; s++) begin
			u_feed.push(16'hc3a5);
			if (s == 2)
				u_feed.push(16'h1e0f);
			dec({10'h0, MODE_EXT, REG_IMM}, size_e'(s), 1'b0, 8'h00, 1'b1);
			chk({ans, ctl.operand, ext_count}, {2'b10, ex[s], (s == 2) ? 8'h02 : 8'h01});
		end
	endtask

	// coprocessor immediate longer than two words; stash keeps every word
	task automatic t_cop();
		logic [15:0] cw[3] = '{16'h1111, 16'h2222, 16'h3333};
		for (int i = 0; i < 3; i++)
			u_feed.push(cw[i]);
		dec({10'h0, MODE_EXT, REG_IMM}, SZ_LONG, 1'b1, 8'h03, 1'b1);
		chk({ans, ctl.operand, ext_count}, {2'b10, 32'h22223333, 8'h03});
		// read the three filled stash slots back; data come one cycle after the address
		for (int i = 0; i < 3; i++) begin
			@(posedge clk);
			rd_idx <= 4'(i);
			@(posedge clk);
			#1;
			chk(rd_data, cw[i]);
		end
	endtask

	task automatic t_full();
		fcase({1'b1, 3'h5, 1'b1, 2'h3, 1'b1, 1'b1, 1'b0, 2'h3, 1'b0, 3'h7}, 64'h12345678_9abcdef0, 4, 1'b1,
			{1'b1, 1'b1, 3'h5, 1'b1, 2'h3, 1'b0, 1'b1, 2'h2, 2'h2, 1'b1, 1'b1, 32'h12345678, 32'h9abcdef0},
			8'h05);
		fcase({1'b0, 3'h2, 1'b0, 2'h1, 1'b1, 1'b0, 1'b1, 2'h3, 1'b0, 3'h3}, 64'hfedc0001_00020003, 4, 1'b0,
			{1'b1, 1'b0, 3'h2, 1'b0, 2'h1, 1'b1, 1'b0, 2'h2, 2'h2, 1'b1, 1'b0, 32'hfedc0001, 32'h00020003},
			8'h0a);
		fcase({1'b0, 3'h1, 1'b0, 2'h0, 1'b1, 1'b0, 1'b0, 2'h2, 1'b0, 3'h2}, 64'h8001_7f00_0000_0000, 2, 1'b1,
			{1'b1, 1'b0, 3'h1, 1'b0, 2'h0, 1'b1, 1'b1, 2'h1, 2'h1, 1'b1, 1'b0, 32'hffff8001, 32'h00007f00},
			8'h03);
		fcase({1'b0, 3'h0, 1'b0, 2'h0, 1'b1, 1'b0, 1'b1, 2'h1, 1'b0, 3'h0}, 64'h0, 0, 1'b1,
			{1'b1, 1'b0, 3'h0, 1'b0, 2'h0, 1'b1, 1'b0, 2'h0, 2'h0, 1'b0, 1'b0, 32'h0, 32'h0}, 8'h01);
	endtask

	// reserved size code and reserved select combinations are refused
	task automatic t_bad();
		logic [15:0] bw[3] = '{16'h0100, 16'h0114, 16'h0155};
		for (int i = 0; i < 3; i++) begin
			u_feed.push(bw[i]);
			dec({10'h0, MODE_IDX, 3'h1}, SZ_WORD, 1'b0, 8'h00, 1'b1);
			chk({ans, word_ready}, {2'b01, 1'b0});
		end
	endtask

	task automatic t_brief();
		u_feed.push({1'b0, 3'h4, 1'b0, 2'h2, 1'b0, 8'h90});
		dec({10'h0, MODE_EXT, REG_PC_IDX}, SZ_WORD, 1'b0, 8'h00, 1'b1);
		chk({ans, ctl.full_fmt, ctl.idx_addr, ctl.idx_reg, ctl.idx_long, ctl.scale_shift, ctl.bd},
			{2'b10, 1'b0, 1'b0, 3'h4, 1'b0, 2'h2, 32'hffffff90});
		chk({ctl.base_add, ctl.index_add}, 2'b11);
	endtask

	// ==========================================
	// main sequence and watchdog
	initial begin
		nrst = 1'b0;
		start = 1'b0;
		clear_count = 1'b0;
		coproc = 1'b0;
		slow = 1'b0;
		instr_word = 16'h0;
		op_size = SZ_BYTE;
		coproc_words = 8'h00;
		rd_idx = 4'h0;
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		t_modes();
		t_imm();
		t_cop();
		t_full();
		t_bad();
		t_brief();
		stop_test();
	end

	// a full run takes about a hundred cycles; this is ample headroom
	initial begin
		repeat (5000) @(posedge clk);
		error_cnt++;
		stop_test();
	end
endmodule
